// *** hdl/pdc_pkg.sv ***
// Package with register map, field layout and reset values of the clock tree configuration.
package pdc_pkg;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h34;
  localparam logic [7:0] ADDR_PRESCALER = 8'h35;
  localparam logic [7:0] ADDR_MULT_HIGH = 8'h36;
  localparam logic [7:0] ADDR_FRAC_LOW = 8'h37;
  localparam logic [7:0] ADDR_INT_LOW = 8'h38;
  localparam logic [7:0] ADDR_N_PDM = 8'h39;
  localparam logic [7:0] ADDR_M_DIV = 8'h3A;
  localparam logic [7:0] RST_SRC_SEL = 8'h10;
  localparam logic [7:0] RST_PRESCALER = 8'h01;
  localparam logic [7:0] RST_MULT_HIGH = 8'h00;
  localparam logic [7:0] RST_FRAC_LOW = 8'h00;
  localparam logic [7:0] RST_INT_LOW = 8'h08;
  localparam logic [7:0] RST_N_PDM = 8'h20;
  localparam logic [7:0] RST_M_DIV = 8'h04;
  // Writable bits of the source select, N/PDM and M divider registers; reserved positions store nothing and read zero.
  localparam logic [7:0] MASK_SRC_SEL = 8'hF0;
  localparam logic [7:0] MASK_N_PDM = 8'hFC;
  localparam logic [7:0] MASK_M_DIV = 8'hFC;
  localparam int DIG_SRC_LSB = 6;
  localparam int ANA_SRC_LSB = 4;
  localparam int INT_HIGH_BIT = 7;
  localparam int HALVE_BIT = 6;
  localparam int N_DIV_LSB = 5;
  localparam int PDM_CLOCK_DIVIDER_LSB = 2;
  localparam int M_DIV_LSB = 2;
  localparam logic [13:0] FRAC_MAX = 14'h270F;
  localparam logic [13:0] FRAC_SCALE = 14'h2710;
  // Automatic-detection values used in place of the programmed ones; the prescale value is added to auto_prescale_hint.
  localparam logic [8:0] AUTO_PRESCALE = 9'h001;
  localparam logic [8:0] AUTO_INT_MULT = 9'h008;
  localparam logic [13:0] AUTO_FRAC_MULT = 14'h0000;
  localparam logic [3:0] AUTO_N_DIV = 4'h1;
  localparam logic [4:0] AUTO_PDM_CLOCK_DIVIDER = 5'h01;
  localparam logic [6:0] AUTO_M_DIV = 7'h01;
  typedef enum logic [3:0] {
    PDC_SRC_PRIMARY_BCLK = 4'h1,
    PDC_SRC_SECONDARY_BCLK = 4'h2,
    PDC_SRC_CONTROLLER_CLK = 4'h4,
    PDC_SRC_OSCILLATOR = 4'h8
  } pdc_src_e;
  typedef enum logic [2:0] {
    PDC_ANA_PLL = 3'h1,
    PDC_ANA_DIG_SOURCE = 3'h2,
    PDC_ANA_LOW_JITTER = 3'h4
  } pdc_ana_e;
endpackage

// *** hdl/pdc_decode.sv ***
// Decoder turning raw divider codes into actual division ratios.
`timescale 1ns/100ps
module pdc_decode (
  input wire logic [7:0] pll_prescaler_value,
  input wire logic [2:0] n_stage_divider,
  input wire logic [2:0] pdm_clock_divider,
  input wire logic [5:0] m_stage_divider_value,
  output logic [8:0] prescale_ratio,
  output logic [3:0] n_ratio,
  output logic [4:0] pdm_ratio,
  output logic pdm_code_bad,
  output logic [6:0] m_ratio
);
  // Zero code means the field's full power of two.
  function automatic logic [8:0] zero_is_max(input logic [7:0] code, input logic [8:0] top);
    zero_is_max = (code == 8'h00) ? top : {1'b0, code};
  endfunction

  logic [8:0] n_full;
  logic [8:0] m_full;

  always_comb
  begin
    prescale_ratio = zero_is_max(pll_prescaler_value, 9'h100);
    n_full = zero_is_max({5'h00, n_stage_divider}, 9'h008);
    n_ratio = n_full[3:0];
    m_full = zero_is_max({2'h0, m_stage_divider_value}, 9'h040);
    m_ratio = m_full[6:0];
    pdm_code_bad = (pdm_clock_divider > 3'h4);
    pdm_ratio = pdm_code_bad ? 5'h01 : 5'(5'h01 << pdm_clock_divider);
  end
endmodule

// *** hdl/pdc_clock_config.sv ***
// Clock tree configuration registers with the decoded divider and PLL settings.
`timescale 1ns/100ps
module pdc_clock_config (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic auto_detect_en,
  input wire logic custom_clock_mode,
  input wire logic [3:0] auto_prescale_hint,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic [3:0] digital_ratio_divider_source,
  output logic [2:0] analog_ratio_divider_source,
  output logic [8:0] prescale_ratio,
  output logic [8:0] pll_integer_mult,
  output logic [13:0] pll_fraction_mult,
  output logic pll_halve_output,
  output logic [3:0] n_ratio,
  output logic [4:0] pdm_ratio,
  output logic [6:0] m_ratio,
  output logic config_error,
  output logic [31:0] pll_gain_x10k
);
  logic rst_meta_n;
  logic rst_n;
  logic [7:0] src_sel;
  logic [7:0] prescaler;
  logic [7:0] mult_high;
  logic [7:0] frac_low;
  logic [7:0] int_low;
  logic [7:0] n_pdm;
  logic [7:0] m_div;
  logic [8:0] dec_prescale;
  logic [3:0] dec_n;
  logic [4:0] dec_pdm;
  logic dec_pdm_bad;
  logic [6:0] dec_m;
  logic [8:0] next_int_mult;
  logic [13:0] next_frac_mult;
  logic [1:0] dig_code;
  logic [1:0] ana_code;
  logic [7:0] next_rdata;
  logic next_hit;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Register writes; reserved positions are masked off so they read zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_sel <= pdc_pkg::RST_SRC_SEL;
      prescaler <= pdc_pkg::RST_PRESCALER;
      mult_high <= pdc_pkg::RST_MULT_HIGH;
      frac_low <= pdc_pkg::RST_FRAC_LOW;
      int_low <= pdc_pkg::RST_INT_LOW;
      n_pdm <= pdc_pkg::RST_N_PDM;
      m_div <= pdc_pkg::RST_M_DIV;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        pdc_pkg::ADDR_SRC_SEL: src_sel <= reg_wdata & pdc_pkg::MASK_SRC_SEL;
        pdc_pkg::ADDR_PRESCALER: prescaler <= reg_wdata;
        pdc_pkg::ADDR_MULT_HIGH: mult_high <= reg_wdata;
        pdc_pkg::ADDR_FRAC_LOW: frac_low <= reg_wdata;
        pdc_pkg::ADDR_INT_LOW: int_low <= reg_wdata;
        pdc_pkg::ADDR_N_PDM: n_pdm <= reg_wdata & pdc_pkg::MASK_N_PDM;
        pdc_pkg::ADDR_M_DIV: m_div <= reg_wdata & pdc_pkg::MASK_M_DIV;
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    next_hit = 1'b1;
    case (reg_addr)
      pdc_pkg::ADDR_SRC_SEL: next_rdata = src_sel;
      pdc_pkg::ADDR_PRESCALER: next_rdata = prescaler;
      pdc_pkg::ADDR_MULT_HIGH: next_rdata = mult_high;
      pdc_pkg::ADDR_FRAC_LOW: next_rdata = frac_low;
      pdc_pkg::ADDR_INT_LOW: next_rdata = int_low;
      pdc_pkg::ADDR_N_PDM: next_rdata = n_pdm;
      pdc_pkg::ADDR_M_DIV: next_rdata = m_div;
      default:
      begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
      end
    endcase
  end

  // Read data is registered one cycle after the read strobe and held until the next.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  pdc_decode u_decode (
    .pll_prescaler_value(prescaler),
    .n_stage_divider(n_pdm[pdc_pkg::N_DIV_LSB +: 3]),
    .pdm_clock_divider(n_pdm[pdc_pkg::PDM_CLOCK_DIVIDER_LSB +: 3]),
    .m_stage_divider_value(m_div[pdc_pkg::M_DIV_LSB +: 6]),
    .prescale_ratio(dec_prescale),
    .n_ratio(dec_n),
    .pdm_ratio(dec_pdm),
    .pdm_code_bad(dec_pdm_bad),
    .m_ratio(dec_m)
  );

  always_comb
  begin
    next_int_mult = {mult_high[pdc_pkg::INT_HIGH_BIT], int_low};
    next_frac_mult = {mult_high[5:0], frac_low};
    dig_code = src_sel[pdc_pkg::DIG_SRC_LSB +: 2];
    ana_code = src_sel[pdc_pkg::ANA_SRC_LSB +: 2];
  end

  // Clock source steering, one-hot.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      digital_ratio_divider_source <= pdc_pkg::PDC_SRC_PRIMARY_BCLK;
      analog_ratio_divider_source <= pdc_pkg::PDC_ANA_PLL;
    end
    else
    begin
      case (dig_code)
        2'h0: digital_ratio_divider_source <= pdc_pkg::PDC_SRC_PRIMARY_BCLK;
        2'h1: digital_ratio_divider_source <= pdc_pkg::PDC_SRC_SECONDARY_BCLK;
        2'h2: digital_ratio_divider_source <= pdc_pkg::PDC_SRC_CONTROLLER_CLK;
        default: digital_ratio_divider_source <= pdc_pkg::PDC_SRC_OSCILLATOR;
      endcase
      case (ana_code)
        2'h2: analog_ratio_divider_source <= pdc_pkg::PDC_ANA_DIG_SOURCE;
        2'h3: analog_ratio_divider_source <= pdc_pkg::PDC_ANA_LOW_JITTER;
        default: analog_ratio_divider_source <= pdc_pkg::PDC_ANA_PLL;
      endcase
    end
  end

  // Effective settings; automatic detection overrides the programmed ones except the halving bit.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_ratio <= pdc_pkg::AUTO_PRESCALE;
    end
    else if (auto_detect_en)
    begin
      prescale_ratio <= {5'h00, auto_prescale_hint} + pdc_pkg::AUTO_PRESCALE;
    end
    else
    begin
      prescale_ratio <= dec_prescale;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_integer_mult <= pdc_pkg::AUTO_INT_MULT;
    end
    else if (auto_detect_en)
    begin
      pll_integer_mult <= pdc_pkg::AUTO_INT_MULT;
    end
    else
    begin
      pll_integer_mult <= next_int_mult;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_fraction_mult <= pdc_pkg::AUTO_FRAC_MULT;
    end
    else if (auto_detect_en)
    begin
      pll_fraction_mult <= pdc_pkg::AUTO_FRAC_MULT;
    end
    else
    begin
      pll_fraction_mult <= next_frac_mult;
    end
  end

  // The halving bit is not taken over by detection, so it applies in both modes.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_halve_output <= 1'b0;
    end
    else
    begin
      pll_halve_output <= mult_high[pdc_pkg::HALVE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      n_ratio <= pdc_pkg::AUTO_N_DIV;
    end
    else if (auto_detect_en)
    begin
      n_ratio <= pdc_pkg::AUTO_N_DIV;
    end
    else
    begin
      n_ratio <= dec_n;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdm_ratio <= pdc_pkg::AUTO_PDM_CLOCK_DIVIDER;
    end
    else if (auto_detect_en)
    begin
      pdm_ratio <= pdc_pkg::AUTO_PDM_CLOCK_DIVIDER;
    end
    else
    begin
      pdm_ratio <= dec_pdm;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m_ratio <= pdc_pkg::AUTO_M_DIV;
    end
    else if (auto_detect_en)
    begin
      m_ratio <= pdc_pkg::AUTO_M_DIV;
    end
    else
    begin
      m_ratio <= dec_m;
    end
  end

  // Flags settings that software must not program.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_error <= 1'b0;
    end
    else
    begin
      config_error <= !auto_detect_en && ((next_int_mult == 9'h000)
        || (next_frac_mult > pdc_pkg::FRAC_MAX)
        || dec_pdm_bad
        || (dig_code == 2'h3 && !custom_clock_mode));
    end
  end

  // PLL gain scaled by ten thousand, halved when the halving bit is set.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_gain_x10k <= 32'h00000000;
    end
    else if (pll_halve_output)
    begin
      pll_gain_x10k <= (32'(pll_integer_mult) * 32'(pdc_pkg::FRAC_SCALE)
        + 32'(pll_fraction_mult)) >> 1;
    end
    else
    begin
      pll_gain_x10k <= 32'(pll_integer_mult) * 32'(pdc_pkg::FRAC_SCALE)
        + 32'(pll_fraction_mult);
    end
  end
endmodule

// *** bench/pdc_clock_config_sva.sv ***
// Assertion checker for the clock tree configuration block.
`timescale 1ns/100ps
module pdc_clock_config_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic auto_detect_en,
  input wire logic [3:0] digital_ratio_divider_source,
  input wire logic [2:0] analog_ratio_divider_source,
  input wire logic [8:0] prescale_ratio,
  input wire logic [8:0] pll_integer_mult,
  input wire logic [13:0] pll_fraction_mult,
  input wire logic pll_halve_output,
  input wire logic [3:0] n_ratio,
  input wire logic [4:0] pdm_ratio,
  input wire logic [6:0] m_ratio,
  input wire logic config_error,
  input wire logic [31:0] pll_gain_x10k
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  dig_src_a: assert property (reg_wr && reg_addr == 8'h34 |=> ##1
    digital_ratio_divider_source == 4'h1 << $past(reg_wdata[7:6], 2)) else $error("dig src");
  ana_src_a: assert property (reg_wr && reg_addr == 8'h34 |=> ##1
    analog_ratio_divider_source ==
    ($past(reg_wdata[5], 2) ? 3'h2 << $past(reg_wdata[4], 2) : 3'h1)) else $error("ana src");
  prescale_code_a: assert property (reg_wr && reg_addr == 8'h35 ##1 !auto_detect_en |=>
    prescale_ratio == {$past(reg_wdata, 2) == 8'h00, $past(reg_wdata, 2)}) else $error("pre");
  auto_override_a: assert property (auto_detect_en |=>
    n_ratio == 4'h1 && m_ratio == 7'h01 && pdm_ratio == 5'h01 && pll_integer_mult == 9'h008 &&
    pll_fraction_mult == 14'h0000 && !config_error) else $error("auto");
  n_div_a: assert property (reg_wr && reg_addr == 8'h39 ##1 !auto_detect_en |=> n_ratio ==
    {$past(reg_wdata[7:5], 2) == 3'h0, $past(reg_wdata[7:5], 2)}) else $error("n div");
  pdm_clock_divider_a: assert property (reg_wr && reg_addr == 8'h39 ##1 !auto_detect_en |=>
    pdm_ratio == ($past(reg_wdata[4:2], 2) > 3'h4 ? 5'h01 :
    5'h01 << $past(reg_wdata[4:2], 2))) else $error("pdm");
  m_div_a: assert property (reg_wr && reg_addr == 8'h3A ##1 !auto_detect_en |=> m_ratio ==
    {$past(reg_wdata[7:2], 2) == 6'h00, $past(reg_wdata[7:2], 2)}) else $error("m div");
  int_low_a: assert property (reg_wr && reg_addr == 8'h38 ##1 !auto_detect_en |=>
    pll_integer_mult[7:0] == $past(reg_wdata, 2)) else $error("int mult");
  halve_bit_a: assert property (reg_wr && reg_addr == 8'h36 |=> ##1
    pll_halve_output == $past(reg_wdata[6], 2)) else $error("halve");
  gain_calc_a: assert property (reg_wr |=> ##2
    pll_gain_x10k == (32'($past(pll_integer_mult)) * 32'h2710 +
    32'($past(pll_fraction_mult))) >> $past(pll_halve_output)) else $error("gain");
endmodule
bind pdc_clock_config pdc_clock_config_sva chk_u (.core_clk, .arst_n, .reg_wr, .reg_addr,
  .reg_wdata, .auto_detect_en, .digital_ratio_divider_source, .analog_ratio_divider_source,
  .prescale_ratio, .pll_integer_mult, .pll_fraction_mult, .pll_halve_output, .n_ratio,
  .pdm_ratio, .m_ratio, .config_error, .pll_gain_x10k);

// *** bench/test_pdc_clock_config.sv ***
// Self-checking testbench for the clock tree configuration block.
`timescale 1ns/100ps
module test_pdc_clock_config;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic auto_detect_en = 1'b0;
  logic custom_clock_mode = 1'b0;
  logic [3:0] auto_prescale_hint = 4'h0;
  logic [7:0] reg_rdata;
  logic reg_hit, halve, cfg_err, rd_seen = 1'b0;
  logic [3:0] dig, n_r;
  logic [2:0] ana;
  logic [8:0] pre, int_m, jm;
  logic [13:0] frac_m, fr;
  logic [4:0] pdm_r;
  logic [6:0] m_r;
  logic [31:0] gain;
  logic [7:0] val;
  logic [8:0] rd_q[$];
  logic [7:0] rst_v[7] = '{8'h10, 8'h01, 8'h00, 8'h00, 8'h08, 8'h20, 8'h04};
  // Bit 5 of the high multiplier byte stays clear so the random fraction never exceeds 9999.
  logic [7:0] mask_v[7] = '{8'hF0, 8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFC, 8'hFC};
  int bad_count = 0;
  int check_count = 0;
  integer seed = 32'h794d;
  always #25 core_clk = ~core_clk;
  pdc_clock_config dut_u (.core_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .auto_detect_en, .custom_clock_mode, .auto_prescale_hint, .reg_rdata, .reg_hit,
    .digital_ratio_divider_source(dig), .analog_ratio_divider_source(ana),
    .prescale_ratio(pre), .pll_integer_mult(int_m), .pll_fraction_mult(frac_m),
    .pll_halve_output(halve), .n_ratio(n_r), .pdm_ratio(pdm_r), .m_ratio(m_r),
    .config_error(cfg_err), .pll_gain_x10k(gain));
  task automatic cmp_cfg(input logic [31:0] got, input logic [31:0] want, input string what);
    check_count++;
    if (got !== want)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %0h want %0h", $time, what, got, want);
    end
  endtask
  task automatic cmp_rd(input logic [8:0] got, input logic [8:0] want);
    cmp_cfg(32'(got), 32'(want), "read");
  endtask
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] want);
    rd_q.push_back(want);
    access(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data stands one cycle after the read edge, so it is compared at the next edge.
  always @(posedge core_clk)
  begin
    if (rd_seen)
      cmp_rd({reg_hit, reg_rdata}, rd_q.pop_front());
    rd_seen <= reg_rd;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 7; i++)
      rd(8'h34 + 8'(i), {1'b1, rst_v[i]});
    for (int i = 0; i < 7; i++)
    begin
      val = 8'($random(seed)) & mask_v[i];
      access(1'b1, 8'h34 + 8'(i), val);
      rd(8'h34 + 8'(i), {1'b1, val});
    end
    rd(8'h3B, 9'h000);
    access(1'b1, 8'h38, 8'h08);
    access(1'b1, 8'h36, 8'h00);
    access(1'b1, 8'h37, 8'h00);
    access(1'b1, 8'h39, 8'h20);
    for (int c = 0; c < 4; c++)
    begin
      access(1'b1, 8'h34, {2'(c), 2'(c), 4'h0});
      settle;
      cmp_cfg(32'(dig), 32'h1 << c, "dig src");
      cmp_cfg(32'(ana), c < 2 ? 32'h1 : 32'h1 << (c - 1), "ana src");
      cmp_cfg(32'(cfg_err), 32'(c == 3), "osc guard");
    end
    custom_clock_mode = 1'b1;
    settle;
    cmp_cfg(32'(cfg_err), 32'h0, "osc custom");
    access(1'b1, 8'h34, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      val = i == 0 ? 8'h00 : i == 1 ? 8'h01 : i == 2 ? 8'hFF : 8'($random(seed));
      access(1'b1, 8'h35, val);
      settle;
      cmp_cfg(32'(pre), val == 8'h00 ? 32'd256 : 32'(val), "prescale");
    end
    for (int c = 0; c < 8; c++)
    begin
      access(1'b1, 8'h39, {3'(c), 3'(c), 2'b00});
      access(1'b1, 8'h3A, {6'(c * 9), 2'b00});
      settle;
      cmp_cfg(32'(n_r), c == 0 ? 32'd8 : 32'(c), "n div");
      cmp_cfg(32'(pdm_r), c > 4 ? 32'd1 : 32'h1 << c, "pdm_clock_divider");
      cmp_cfg(32'(cfg_err), 32'(c > 4), "pdm code");
      cmp_cfg(32'(m_r), c == 0 ? 32'd64 : 32'(c * 9), "m div");
    end
    for (int i = 0; i < 4; i++)
    begin
      jm = i == 0 ? 9'h1FF : 9'($unsigned($random(seed)) % 511 + 1);
      fr = i == 0 ? 14'd9999 : 14'($unsigned($random(seed)) % 10000);
      access(1'b1, 8'h36, {jm[8], i[0], fr[13:8]});
      access(1'b1, 8'h37, fr[7:0]);
      access(1'b1, 8'h38, jm[7:0]);
      settle;
      cmp_cfg(32'(int_m), 32'(jm), "int mult");
      cmp_cfg(32'(frac_m), 32'(fr), "frac mult");
      cmp_cfg(32'(halve), 32'(i[0]), "halve");
      cmp_cfg(gain, (32'(jm) * 10000 + 32'(fr)) >> i[0], "gain");
    end
    auto_prescale_hint = 4'($random(seed));
    auto_detect_en = 1'b1;
    settle;
    cmp_cfg(32'({pre, n_r, pdm_r, m_r}),
      32'({9'(auto_prescale_hint) + 9'h1, 4'h1, 5'h1, 7'h1}), "auto");
    cmp_cfg(32'({int_m, frac_m, cfg_err}), 32'({9'h8, 14'h0, 1'b0}), "auto pll");
    tally_and_finish;
  end
endmodule
